/* audio_pll_clock_config.sv */
// audio pll configuration registers and audio clock gating, ahb-lite slave
// assumes the analog pll1 sits outside, fed by the shared 15 MHz crystal,
// and returns its output on pll1_fout, well below half of ref_clk
//
// How it works
// - powerdown bit high holds pll1 down; resets high
// - feedback factor is bits 15:7 plus two
// - input factor is bits 4:0 plus two
// - output divider code 00/01/10/11 gives 1/2/2/4
// - fout is fin times nf over nr over no
// - pll1 uses the system pll crystal reference
// - enable bit 8 gates pll1 to audio clock
// - audio clock is fout over divisor plus one
`timescale 1ns/10ps
module audio_pll_clock_config
  import audio_pll_clock_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // analog pll1 control
  output logic audio_pll_powerdown,
  output logic [9:0] audio_pll_feedback_factor,
  output logic [5:0] audio_pll_input_factor,
  output logic [2:0] audio_pll_output_factor,
  // clocks
  input wire logic pll1_fout,
  output logic audio_clk
);
  logic [1:0] reset_sync;
  logic rst_n;
  logic [1:0] fout_sync;
  logic [31:0] audio_pll_config;
  logic [31:0] audio_clock_gate_audio_clock_divisor;
  logic [31:0] next_audio_pll_config;
  logic [31:0] next_audio_clock_gate_audio_clock_divisor;
  logic write_pending;
  logic [31:0] write_addr;
  logic access_valid;

  function automatic logic [31:0] read_value(input logic [31:0] addr,
                                             input logic [31:0] cfg,
                                             input logic [31:0] gate);
    if (addr == ADDR_AUDIO_PLL_CONFIG) begin
      read_value = cfg & MASK_AUDIO_PLL_CONFIG;
    end else if (addr == ADDR_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR) begin
      read_value = gate & MASK_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR;
    end else begin
      read_value = '0;
    end
  endfunction

  function automatic logic [2:0] output_factor(input logic [1:0] code);
    unique case (code)
      2'h0: output_factor = 3'h1;
      2'h1: output_factor = 3'h2;
      2'h2: output_factor = 3'h2;
      2'h3: output_factor = 3'h4;
    endcase
  endfunction

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_sync <= 2'h0;
    end else begin
      reset_sync <= {reset_sync[0], 1'b1};
    end
  end
  assign rst_n = reset_sync[1];

  // pll1 output is asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fout_sync <= 2'h0;
    end else begin
      fout_sync <= {fout_sync[0], pll1_fout};
    end
  end

  assign access_valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // zero wait states: address phase captured here, data written next edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_pending <= 1'b0;
      write_addr <= '0;
    end else begin
      write_pending <= access_valid && hwrite;
      write_addr <= haddr;
    end
  end

  always_comb begin
    next_audio_pll_config = audio_pll_config;
    next_audio_clock_gate_audio_clock_divisor = audio_clock_gate_audio_clock_divisor;
    if (write_pending && write_addr == ADDR_AUDIO_PLL_CONFIG) begin
      next_audio_pll_config = hwdata & MASK_AUDIO_PLL_CONFIG;
    end
    if (write_pending && write_addr == ADDR_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR) begin
      next_audio_clock_gate_audio_clock_divisor = hwdata & MASK_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      audio_pll_config <= RESET_AUDIO_PLL_CONFIG;
      audio_clock_gate_audio_clock_divisor <= RESET_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR;
    end else begin
      audio_pll_config <= next_audio_pll_config;
      audio_clock_gate_audio_clock_divisor <= next_audio_clock_gate_audio_clock_divisor;
    end
  end

  // read data taken from next values so a read right after a write sees it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      if (access_valid && !hwrite) begin
        hrdata <= read_value(haddr, next_audio_pll_config, next_audio_clock_gate_audio_clock_divisor);
      end
    end
  end

  // analog pll1 controls; its reference is the shared crystal, no select
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      audio_pll_powerdown <= RESET_AUDIO_PLL_CONFIG[POWERDOWN_BIT];
      audio_pll_feedback_factor <= FEEDBACK_OFFSET;
      audio_pll_input_factor <= INPUT_DIV_OFFSET;
      audio_pll_output_factor <=
        output_factor(RESET_AUDIO_PLL_CONFIG[OUTPUT_DIV_MSB:OUTPUT_DIV_LSB]);
    end else begin
      audio_pll_powerdown <= audio_pll_config[POWERDOWN_BIT];
      // factors applied by pll1: fout = fin * nf / nr / no
      audio_pll_feedback_factor <= {1'b0, audio_pll_config[FEEDBACK_MSB:FEEDBACK_LSB]}
                                   + FEEDBACK_OFFSET;
      audio_pll_input_factor <= {1'b0, audio_pll_config[INPUT_DIV_MSB:INPUT_DIV_LSB]}
                                + INPUT_DIV_OFFSET;
      audio_pll_output_factor <=
        output_factor(audio_pll_config[OUTPUT_DIV_MSB:OUTPUT_DIV_LSB]);
    end
  end

  // a powered-down pll1 still passes its (flat) output when enabled;
  // software owns the ordering of enable and powerdown
  audio_clock_divider #(
    .WIDTH(DIVISOR_WIDTH)
  ) divider (
    .clk(ref_clk),
    .rst_n(rst_n),
    .enable(audio_clock_gate_audio_clock_divisor[SOURCE_ENABLE_BIT]),
    .divisor(audio_clock_gate_audio_clock_divisor[DIVISOR_MSB:DIVISOR_LSB]),
    .fout_level(fout_sync[1]),
    .audio_clk(audio_clk)
  );

  a_powerdown_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 audio_pll_powerdown == $past(audio_pll_config[POWERDOWN_BIT]))
    else $error("powerdown output does not follow register");
  // factors lag the register by one edge, so compare against its previous value
  a_feedback_plus2: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $stable(audio_pll_config) |=> audio_pll_feedback_factor ==
      10'($past(audio_pll_config[FEEDBACK_MSB:FEEDBACK_LSB])) + 10'h002)
    else $error("feedback factor wrong");
  a_input_plus2: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $stable(audio_pll_config) |=> audio_pll_input_factor ==
      6'($past(audio_pll_config[INPUT_DIV_MSB:INPUT_DIV_LSB])) + 6'h02)
    else $error("input factor wrong");
  a_output_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (audio_pll_config[OUTPUT_DIV_MSB:OUTPUT_DIV_LSB] == 2'h3 && $stable(audio_pll_config))
      |=> audio_pll_output_factor == 3'h4)
    else $error("output divider decode wrong");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (audio_pll_config & ~MASK_AUDIO_PLL_CONFIG) == '0 &&
    (audio_clock_gate_audio_clock_divisor & ~MASK_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR) == '0)
    else $error("reserved bits set");
  a_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (access_valid && hwrite && haddr == ADDR_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR) ##1 1'b1
      |=> audio_clock_gate_audio_clock_divisor == ($past(hwdata) & MASK_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR))
    else $error("gate register write lost");
  c_power_up: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(audio_pll_powerdown));
  c_enable_gate: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(audio_clock_gate_audio_clock_divisor[SOURCE_ENABLE_BIT]));
  c_read_back: cover property (@(posedge ref_clk) disable iff (!rst_n)
    access_valid && !hwrite && haddr == ADDR_AUDIO_PLL_CONFIG);
endmodule // audio_pll_clock_config

/* audio_pll_clock_pkg.sv */
// constants for the audio pll configuration and audio clock gating block
// assumes a 32-bit ahb-lite register port and a 20 MHz ref_clk
package audio_pll_clock_pkg;
  localparam logic [31:0] ADDR_AUDIO_PLL_CONFIG = 32'hfff0_0010;
  localparam logic [31:0] ADDR_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR = 32'hfff0_0014;
  localparam logic [31:0] RESET_AUDIO_PLL_CONFIG = 32'h0001_0000;
  localparam logic [31:0] RESET_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR = 32'h0000_0000;
  // writable bits; everything else is reserved
  localparam logic [31:0] MASK_AUDIO_PLL_CONFIG = 32'h0001_ffff;
  localparam logic [31:0] MASK_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR = 32'h0000_01ff;
  localparam int POWERDOWN_BIT = 16;
  localparam int FEEDBACK_MSB = 15;
  localparam int FEEDBACK_LSB = 7;
  localparam int OUTPUT_DIV_MSB = 6;
  localparam int OUTPUT_DIV_LSB = 5;
  localparam int INPUT_DIV_MSB = 4;
  localparam int INPUT_DIV_LSB = 0;
  localparam int SOURCE_ENABLE_BIT = 8;
  localparam int DIVISOR_MSB = 7;
  localparam int DIVISOR_LSB = 0;
  localparam int FEEDBACK_WIDTH = 9;
  localparam int INPUT_DIV_WIDTH = 5;
  localparam int DIVISOR_WIDTH = 8;
  localparam logic [9:0] FEEDBACK_OFFSET = 10'h002;
  localparam logic [5:0] INPUT_DIV_OFFSET = 6'h02;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;
  localparam int REF_CLK_MHZ = 20;
  localparam int CRYSTAL_KHZ = 15000;
endpackage

/* audio_clock_divider.sv */
// divides the synchronised pll1 output by divisor+1 and gates it
// assumes fout_level is already synchronised to clk and well below clk/2
`timescale 1ns/10ps
module audio_clock_divider
  import audio_pll_clock_pkg::*;
#(
  parameter int WIDTH = DIVISOR_WIDTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic [WIDTH-1:0] divisor,
  // clocks
  input wire logic fout_level,
  output logic audio_clk
);
  logic prev_level;
  logic [WIDTH-1:0] edge_count;
  logic any_edge;

  assign any_edge = fout_level != prev_level;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_level <= 1'b0;
    end else begin
      prev_level <= fout_level;
    end
  end

  // toggling every divisor+1 edges of either kind gives a period of
  // divisor+1 source periods; divisor zero simply follows the source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_count <= '0;
      audio_clk <= 1'b0;
    end else if (!enable) begin
      edge_count <= '0;
      audio_clk <= 1'b0;
    end else if (any_edge) begin
      if (edge_count >= divisor) begin
        edge_count <= '0;
        audio_clk <= ~audio_clk;
      end else begin
        edge_count <= edge_count + 1'b1;
      end
    end
  end

  a_gate_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    !enable |=> !audio_clk)
    else $error("audio clock moved while source disabled");
  // phase against the source depends on when enable rose, so only the toggle is checked
  a_passthrough_follow: assert property (@(posedge clk) disable iff (!rst_n)
    (enable && divisor == '0 && $past(enable) && any_edge) |=> audio_clk != $past(audio_clk))
    else $error("divisor zero does not follow source");
  a_toggle_needs_count: assert property (@(posedge clk) disable iff (!rst_n)
    (enable && $changed(audio_clk)) |-> ($past(any_edge) && $past(edge_count) >= $past(divisor)))
    else $error("audio clock toggled before count reached");
  c_divided_toggle: cover property (@(posedge clk) disable iff (!rst_n)
    enable && divisor == 8'h03 && $rose(audio_clk));
endmodule // audio_clock_divider

/* audio_clk_monitor.sv */
// audio serial controller clock input: counts audio clock rising edges
// assumes audio_clk is slow enough to be seen by ref_clk sampling
`timescale 1ns/10ps
module audio_clk_monitor (
  // clock
  input wire logic ref_clk,
  // audio side
  input wire logic audio_clk,
  input wire logic clear,
  output int rises
);
  logic last;
  always @(posedge ref_clk) begin
    last <= audio_clk;
    if (clear) rises <= 0;
    else if (audio_clk && !last) rises <= rises + 1;
  end
endmodule // audio_clk_monitor

/* tb.sv */
// self-checking bench for the audio pll configuration block
// assumes one ahb-lite master (this bench) and a slow free-running pll1 output
`timescale 1ns/10ps
module tb;
  import audio_pll_clock_pkg::*;
  logic ref_clk = 0, reset_n = 0, hsel = 0, hwrite = 0, pll1_fout = 0, clr = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, pd, audio_clk;
  logic [9:0] nf;
  logic [5:0] nr;
  logic [2:0] no;
  int rises, bad_count = 0, checks_done = 0;
  always #25 ref_clk = ~ref_clk;
  // pll1 stand-in: period of 8 ref_clk cycles, well under half of ref_clk
  always begin
    repeat (4) @(posedge ref_clk);
    pll1_fout <= ~pll1_fout;
  end
  audio_pll_clock_config DUT (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .audio_pll_powerdown(pd), .audio_pll_feedback_factor(nf), .audio_pll_input_factor(nr),
    .audio_pll_output_factor(no), .pll1_fout(pll1_fout), .audio_clk(audio_clk));
  audio_clk_monitor far_end (.ref_clk(ref_clk), .audio_clk(audio_clk), .clear(clr),
    .rises(rises));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single transfer; called just after a rising edge
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= HTRANS_NONSEQ;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0; hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    q = hrdata;
    check(hresp, HRESP_OKAY);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
    // pll outputs move at the edge after the register; look one edge later
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic rd_check(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    check(q, exp);
  endtask
  task automatic t_reset;
    check(pd, 1'b1);
    check(nf, 10'h002);
    check(nr, 6'h02);
    check(no, 3'h1);
    check(audio_clk, 1'b0);
    rd_check(ADDR_AUDIO_PLL_CONFIG, 32'h0001_0000);
    rd_check(ADDR_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR, 32'h0000_0000);
  endtask
  task automatic t_config;
    logic [2:0] dec [4] = '{3'h1, 3'h2, 3'h2, 3'h4};
    logic [8:0] fb;
    logic [4:0] ind;
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      fb = 9'h0ff + 9'h080 * k[8:0];
      ind = 5'h1c + k[4:0];
      // reserved bits written as ones must not stick
      wr(ADDR_AUDIO_PLL_CONFIG, {15'h7fff, 1'b0, fb, c, ind});
      check(pd, 1'b0);
      check(nf, {1'b0, fb} + 10'h002);
      check(nr, {1'b0, ind} + 6'h02);
      check(no, dec[k]);
      rd_check(ADDR_AUDIO_PLL_CONFIG, {16'h0, fb, c, ind});
    end
    wr(ADDR_AUDIO_PLL_CONFIG, 32'hffff_ffff);
    check(pd, 1'b1);
    check({nf, nr, no}, {10'h201, 6'h21, 3'h4});
    wr(32'hfff0_0018, 32'h0000_0000);
    rd_check(32'hfff0_0018, 32'h0000_0000);
    rd_check(ADDR_AUDIO_PLL_CONFIG, 32'h0001_ffff);
  endtask
  // audio clock period must be (divisor+1) pll1 periods
  task automatic t_gate;
    logic [7:0] dv [3] = '{8'h00, 8'h01, 8'h03};
    for (int k = 0; k < 3; k++) begin
      // software picks a divisor giving the wanted audio rate
      wr(ADDR_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR, {23'h7fffff, 1'b1, dv[k]});
      rd_check(ADDR_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR, {23'h0, 1'b1, dv[k]});
      repeat (40) @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      repeat (128 * (dv[k] + 1)) @(posedge ref_clk);
      check(rises >= 15 && rises <= 17, 1'b1);
    end
    wr(ADDR_AUDIO_CLOCK_GATE_AUDIO_CLOCK_DIVISOR, 32'hffff_fe05);
    repeat (20) @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (200) @(posedge ref_clk);
    check(rises, 0);
    check(audio_clk, 1'b0);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_config();
    t_gate();
    summarize();
  end
  // whole run needs about 1300 cycles; allow far more
  initial begin
    #(50 * 40000);
    bad_count++;
    summarize();
  end
endmodule // tb
